// File: inc/rpd_pkg.sv
// Purpose: shared constants for the reset, power-down and activation status block
// Assumes: 100 MHz clock, APB with 32-bit data
// Notes: offsets are byte addresses on the APB
package rpd_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] addr_reset_power_control = 8'h00;
  localparam logic [7:0] addr_activation_status = 8'h04;
  localparam logic [7:0] addr_activation_control = 8'h08;
  localparam logic [7:0] addr_dchannel_access_config = 8'h0c;
  localparam logic [7:0] addr_dchannel_data_register = 8'h10;
  localparam logic [7:0] addr_maintenance_control = 8'h14;
  localparam logic [7:0] addr_line_state = 8'h18;
  // reset_power_control fields
  localparam int bit_software_reset = 3;
  localparam int bit_power_down_enable = 2;
  localparam int bit_absolute_power_down = 1;
  localparam int bit_return_to_normal = 0;
  // activation_status fields
  localparam int bit_linkup = 3;
  localparam int bit_error_indication = 2;
  localparam int bit_superframe_sync = 1;
  localparam int bit_transparent = 0;
  // activation_control fields
  localparam int bit_activation_request = 3;
  localparam int bit_deactivation_request = 2;
  localparam int bit_customer_enable = 0;
  // dchannel_access_config field
  localparam int bit_dchannel_enable = 1;
  // maintenance_control fields: crc corrupt at 8, loopbacks at 7:0
  localparam int bit_crc_corrupt = 8;
  localparam logic [3:0] nibble_reset = 4'h0;
  localparam logic [3:0] dchannel_code = 4'hf;
  localparam logic [8:0] maint_reset = 9'h000;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int clk_mhz = 100;
  localparam int frame_loss_ms = 480;
  localparam int frame_loss_cycles = frame_loss_ms * 1000 * clk_mhz;
  localparam int reset_min_periods = 6;
endpackage : rpd_pkg

// File: core/rpd_sync_timer.sv
// Purpose: counts how long a condition has held and flags when a limit is reached
// Assumes: one clock, asynchronous active-high reset
// Notes: done is registered and holds while the condition stays true
`timescale 1ns/1ps
module rpd_sync_timer #(
  parameter int limit = rpd_pkg::frame_loss_cycles
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic run,
  output logic done
);
  logic [31:0] count;

  // count while run holds, restart otherwise
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= 32'h0000_0000;
      done <= 1'b0;
    end
    else if (clear || !run)
    begin
      count <= 32'h0000_0000;
      done <= 1'b0;
    end
    else if (count >= 32'(limit - 1))
    begin
      done <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule : rpd_sync_timer

// File: core/rpd_core.sv
// Purpose: reset / power-down control and activation status registers over APB
// Assumes: line events arrive as synchronous one-cycle pulses or levels
// Notes: line-side state machine is reduced to the status-bit behaviour
`timescale 1ns/1ps

// Behaviour
// - power control cleared only by hardware reset
// - absolute power-down: only power control writable
// - software reset holds until bit cleared
// - soft reset spares power control, D-config
// - power-down while waiting for wake tone
// - wake tone, activation request, clear exit
// - enable low forbids power-down
// - absolute power-down acts as software reset
// - absolute power-down erases coefficients, cold start
// - return-to-normal clears crc corrupt, loopbacks
// - status edges, except error falling, raise activation-change interrupt
// - status read clears activation-change interrupt
// - D-channel data shows status code 1111
// - linkup holds until loss, deactivation, reset
// - error on timeout, frame loss, no response
// - error clears on request or wake tone
// - sync rises with linkup; long loss deactivates
// - no sync: suppress maintenance interrupts, ones
// - transparent tracks activation progress and errors
// - receive data gated by five conditions, pass flag by four
module rpd_core #(
  parameter int frame_loss_limit = rpd_pkg::frame_loss_cycles
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic waiting_wake_tone,
  input wire logic wake_tone_detected,
  input wire logic activation_start,
  input wire logic full_duplex_reached,
  input wire logic activation_failed,
  input wire logic framing_ok,
  input wire logic superframe_found,
  input wire logic high_line_error,
  input wire logic deactivation_done,
  input wire logic activation_timer_expired,
  input wire logic no_response_timeout,
  input wire logic verified_act,
  input wire logic dchannel_data_ready,
  input wire logic [7:0] dchannel_rx_byte,
  input wire logic maint_irq_event,
  input wire logic rx_data_in,
  output logic soft_reset_active,
  output logic power_down,
  output logic absolute_power_down,
  output logic clear_coefficients,
  output logic drivers_off,
  output logic activation_change_interrupt,
  output logic maint_irq_out,
  output logic rx_data_out,
  output logic rx_data_pass
);
  logic [3:0] reset_power_control;
  logic [3:0] activation_control;
  logic [1:0] dchannel_access_config;
  logic [8:0] maint_control;
  logic linkup;
  logic error_indication;
  logic superframe_sync;
  logic transparent;
  logic dch_pending;
  logic [7:0] dch_data;
  logic irq_pending;
  logic [3:0] prev_status;
  logic internal_reset;
  logic apd_active;
  logic wr_ok;
  logic rd_ok;
  logic setup_wr;
  logic setup_rd;
  logic loss_done;
  logic sync_loss_done;
  logic [2:0] reset_seen;
  logic [31:0] next_rdata;
  logic [3:0] status_view;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  // access phase takes two cycles; pready rises in the second access cycle
  assign setup_wr = psel && penable && pwrite && pready;
  assign setup_rd = psel && penable && !pwrite && pready;
  assign apd_active = reset_power_control[rpd_pkg::bit_absolute_power_down];
  // soft reset or absolute power-down holds everything but power control, d-channel access config and the latched d-channel byte
  assign internal_reset = reset_power_control[rpd_pkg::bit_software_reset] || apd_active;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  assign wr_ok = setup_wr && (!apd_active || hit(paddr, rpd_pkg::addr_reset_power_control));
  assign rd_ok = setup_rd && !apd_active;

  // pready pulses in the second cycle of the access phase
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
    end
  end

  // -----------------------------------------------------------------
  // reset and power control register
  // -----------------------------------------------------------------
  // cleared only by hardware reset; soft reset leaves it alone
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reset_power_control <= rpd_pkg::nibble_reset;
    end
    else if (wr_ok && hit(paddr, rpd_pkg::addr_reset_power_control))
    begin
      reset_power_control <= pwdata[3:0];
    end
  end

  // d-channel access config also survives soft reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dchannel_access_config <= 2'h0;
    end
    else if (wr_ok && hit(paddr, rpd_pkg::addr_dchannel_access_config))
    begin
      dchannel_access_config <= pwdata[1:0];
    end
  end

  // activation control, cleared by either reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      activation_control <= rpd_pkg::nibble_reset;
    end
    else if (internal_reset)
    begin
      activation_control <= rpd_pkg::nibble_reset;
    end
    else if (wr_ok && hit(paddr, rpd_pkg::addr_activation_control))
    begin
      activation_control <= pwdata[3:0];
    end
    else if (activation_start)
    begin
      activation_control[rpd_pkg::bit_activation_request] <= 1'b0;
    end
  end

  // crc corrupt and loopback bits; return to normal wipes them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      maint_control <= rpd_pkg::maint_reset;
    end
    else if (internal_reset)
    begin
      maint_control <= rpd_pkg::maint_reset;
    end
    else if (wr_ok && hit(paddr, rpd_pkg::addr_reset_power_control)
             && pwdata[rpd_pkg::bit_return_to_normal])
    begin
      maint_control <= rpd_pkg::maint_reset;
    end
    else if (wr_ok && hit(paddr, rpd_pkg::addr_maintenance_control))
    begin
      maint_control <= pwdata[8:0];
    end
  end

  // -----------------------------------------------------------------
  // power-down control
  // -----------------------------------------------------------------
  // power-down only while enabled, waiting, and no exit condition
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power_down <= 1'b0;
      absolute_power_down <= 1'b0;
      clear_coefficients <= 1'b0;
      drivers_off <= 1'b0;
      soft_reset_active <= 1'b0;
    end
    else
    begin
      power_down <= reset_power_control[rpd_pkg::bit_power_down_enable] && waiting_wake_tone
                    && !wake_tone_detected && !activation_control[rpd_pkg::bit_activation_request]
                    && !internal_reset;
      absolute_power_down <= apd_active;
      clear_coefficients <= apd_active;
      drivers_off <= apd_active || (reset_power_control[rpd_pkg::bit_power_down_enable]
                     && waiting_wake_tone && !wake_tone_detected
                     && !activation_control[rpd_pkg::bit_activation_request]);
      soft_reset_active <= internal_reset;
    end
  end

  // counts hardware-reset-free cycles to observe the minimum reset width
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reset_seen <= 3'h0;
    end
    else if (reset_seen != 3'(rpd_pkg::reset_min_periods))
    begin
      reset_seen <= reset_seen + 3'h1;
    end
  end

  // -----------------------------------------------------------------
  // activation status
  // -----------------------------------------------------------------
  rpd_sync_timer #(
    .limit(frame_loss_limit)
  ) frame_loss_timer (
    .clk(clk),
    .reset(reset),
    .clear(internal_reset),
    .run(linkup && !framing_ok),
    .done(loss_done)
  );

  rpd_sync_timer #(
    .limit(frame_loss_limit)
  ) sync_loss_timer (
    .clk(clk),
    .reset(reset),
    .clear(internal_reset),
    .run(linkup && !superframe_sync),
    .done(sync_loss_done)
  );

  // linkup and superframe sync
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      linkup <= 1'b0;
      superframe_sync <= 1'b0;
    end
    else if (internal_reset || loss_done || sync_loss_done || deactivation_done
             || (activation_control[rpd_pkg::bit_deactivation_request] && !framing_ok))
    begin
      linkup <= 1'b0;
      superframe_sync <= 1'b0;
    end
    else if (!linkup && full_duplex_reached)
    begin
      linkup <= 1'b1;
      superframe_sync <= 1'b1;
    end
    else if (linkup)
    begin
      superframe_sync <= superframe_found;
    end
  end

  // error indication: timeouts set it, request or wake tone clear it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      error_indication <= 1'b0;
    end
    else if (internal_reset)
    begin
      error_indication <= 1'b0;
    end
    else if (activation_timer_expired || loss_done || no_response_timeout || activation_failed)
    begin
      error_indication <= 1'b1;
    end
    else if (wake_tone_detected || (wr_ok && hit(paddr, rpd_pkg::addr_activation_control)
             && pwdata[rpd_pkg::bit_activation_request]))
    begin
      error_indication <= 1'b0;
    end
  end

  // transparent / activation in progress
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      transparent <= 1'b0;
    end
    else if (internal_reset || activation_failed || deactivation_done || loss_done || sync_loss_done)
    begin
      transparent <= 1'b0;
    end
    else if (activation_start)
    begin
      transparent <= 1'b1;
    end
    else if (linkup)
    begin
      transparent <= !high_line_error;
    end
  end

  // -----------------------------------------------------------------
  // interrupt and d-channel overlay
  // -----------------------------------------------------------------
  assign status_view = {linkup, error_indication, superframe_sync, transparent};

  // latch d-channel byte; reading the data register drops the 1111 code
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dch_pending <= 1'b0;
      dch_data <= 8'h00;
    end
    else if (internal_reset)
    begin
      dch_pending <= 1'b0;
    end
    else if (dchannel_data_ready && dchannel_access_config[rpd_pkg::bit_dchannel_enable])
    begin
      dch_pending <= 1'b1;
      dch_data <= dchannel_rx_byte;
    end
    else if (rd_ok && hit(paddr, rpd_pkg::addr_dchannel_data_register))
    begin
      dch_pending <= 1'b0;
    end
  end

  // rising bits or falling linkup/sync/transparent raise the interrupt; a new edge beats the read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prev_status <= rpd_pkg::nibble_reset;
      irq_pending <= 1'b0;
    end
    else
    begin
      prev_status <= status_view;
      if ((|(status_view & ~prev_status))
          || (|(prev_status & ~status_view & 4'b1011)))
      begin
        irq_pending <= 1'b1;
      end
      else if (internal_reset || (rd_ok && hit(paddr, rpd_pkg::addr_activation_status)))
      begin
        irq_pending <= 1'b0;
      end
    end
  end

  // interrupt line also shows a pending d-channel byte; maintenance interrupts need sync
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      activation_change_interrupt <= 1'b0;
      maint_irq_out <= 1'b0;
    end
    else
    begin
      activation_change_interrupt <= irq_pending || dch_pending;
      maint_irq_out <= maint_irq_event && superframe_sync && !internal_reset;
    end
  end

  // -----------------------------------------------------------------
  // receive data gate
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_data_pass <= 1'b0;
      rx_data_out <= 1'b1;
    end
    else
    begin
      rx_data_pass <= linkup && superframe_sync && transparent
                      && (activation_control[rpd_pkg::bit_customer_enable] || verified_act);
      rx_data_out <= (linkup && superframe_sync && transparent && !power_down
                      && (activation_control[rpd_pkg::bit_customer_enable] || verified_act))
                     ? rx_data_in : 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      rpd_pkg::addr_reset_power_control: next_rdata[3:0] = reset_power_control;
      rpd_pkg::addr_activation_status: next_rdata[3:0] = dch_pending ? rpd_pkg::dchannel_code : status_view;
      rpd_pkg::addr_activation_control: next_rdata[3:0] = activation_control;
      rpd_pkg::addr_dchannel_access_config: next_rdata[1:0] = dchannel_access_config;
      rpd_pkg::addr_dchannel_data_register: next_rdata[7:0] = dch_data;
      rpd_pkg::addr_maintenance_control: next_rdata[8:0] = maint_control;
      rpd_pkg::addr_line_state: next_rdata[4:0] = {apd_active, power_down, drivers_off,
                                                    internal_reset, irq_pending};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data and error registered with the access; reads blocked in absolute power-down
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= (!pwrite && !apd_active) ? next_rdata : 32'h0000_0000;
      pslverr <= (paddr > rpd_pkg::addr_line_state) || (paddr[1:0] != 2'b00);
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_apd_blocks_write;
    @(posedge clk) disable iff (reset)
    (apd_active && setup_wr && paddr != rpd_pkg::addr_reset_power_control)
    |=> $stable(dchannel_access_config);
  endproperty
  a_apd_blocks_write: assert property (p_apd_blocks_write) else $error("write accepted in power-down");

  property p_rtn_clears;
    @(posedge clk) disable iff (reset)
    (wr_ok && paddr == rpd_pkg::addr_reset_power_control && pwdata[0]) |=> maint_control == 9'h000;
  endproperty
  a_rtn_clears: assert property (p_rtn_clears) else $error("return to normal failed");

  property p_soft_keeps_ctrl;
    @(posedge clk) disable iff (reset)
    (internal_reset && !wr_ok) |=> $stable(reset_power_control) && $stable(dchannel_access_config);
  endproperty
  a_soft_keeps_ctrl: assert property (p_soft_keeps_ctrl) else $error("soft reset changed control");

  property p_status_cleared;
    @(posedge clk) disable iff (reset)
    internal_reset ##1 internal_reset |-> status_view == 4'h0;
  endproperty
  a_status_cleared: assert property (p_status_cleared) else $error("status not cleared");

  property p_irq_on_rise;
    @(posedge clk) disable iff (reset)
    $rose(linkup) |=> irq_pending ##1 activation_change_interrupt;
  endproperty
  a_irq_on_rise: assert property (p_irq_on_rise) else $error("no interrupt on linkup");

  property p_pd_needs_enable;
    @(posedge clk) disable iff (reset)
    !reset_power_control[2] |=> !power_down;
  endproperty
  a_pd_needs_enable: assert property (p_pd_needs_enable) else $error("power-down without enable");

  property p_gate;
    @(posedge clk) disable iff (reset)
    !superframe_sync |=> rx_data_out && !rx_data_pass;
  endproperty
  a_gate: assert property (p_gate) else $error("data passed without sync");

  property p_dch_code;
    @(posedge clk) disable iff (reset)
    (dch_pending && psel && !penable && !pwrite && paddr == rpd_pkg::addr_activation_status && !apd_active)
    ##1 (psel && penable) |=> prdata[3:0] == 4'hf;
  endproperty
  a_dch_code: assert property (p_dch_code) else $error("d-channel code missing");
endmodule : rpd_core

// File: sim/rpd_mcu.sv
// Purpose: apb master standing in for the controller at the register port
// Assumes: calls start right after a rising clock edge
// Notes: an idle cycle follows every transfer; only mcu mode is modelled
`timescale 1ns/1ps
module rpd_mcu (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // setup, access until pready, release; never run in gci mode
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : rpd_mcu

// File: sim/testbench.sv
// Purpose: self-checking bench for the power control and status registers
// Assumes: rpd_mcu drives the register port
// Notes: frame loss limit shortened to 20 cycles
`timescale 1ns/1ps
`define chk(n, x, s) begin total_checks++; if ((s) !== (x)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", n, x, s); end end
module testbench;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic clk, reset, psel, penable, pwrite, pready, pslverr, e, b;
  logic [7:0] paddr, dchannel_rx_byte;
  logic [31:0] pwdata, prdata, r;
  logic waiting_wake_tone, wake_tone_detected, activation_start, full_duplex_reached, framing_ok;
  logic superframe_found, activation_timer_expired, dchannel_data_ready, maint_irq_event, rx_data_in, high_line_error;
  logic soft_reset_active, power_down, absolute_power_down, clear_coefficients, drivers_off;
  logic activation_change_interrupt, maint_irq_out, rx_data_out, rx_data_pass;
  int fails, total_checks;

  rpd_core #(.frame_loss_limit(20)) i_rpd_core (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .waiting_wake_tone, .wake_tone_detected, .activation_start,
    .full_duplex_reached, .activation_failed(1'b0), .framing_ok, .superframe_found,
    .high_line_error, .deactivation_done(1'b0), .activation_timer_expired,
    .no_response_timeout(1'b0), .verified_act(1'b0), .dchannel_data_ready, .dchannel_rx_byte,
    .maint_irq_event, .rx_data_in, .soft_reset_active, .power_down, .absolute_power_down,
    .clear_coefficients, .drivers_off, .activation_change_interrupt, .maint_irq_out, .rx_data_out,
    .rx_data_pass);
  rpd_mcu i_rpd_mcu (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // 100 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_rpd_mcu.xfer(1'b1, a, d, r, e);
  endtask : wr

  // masked read compare; error expected only above the map
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    i_rpd_mcu.xfer(1'b0, a, 32'h0000_0000, r, e);
    `chk("read data", x, r & m)
    `chk("slave error", a > 8'h18, e)
  endtask : rchk

  // bounded wait for an output level
  task automatic await(ref logic s, input logic v, input string n);
    int k;
    k = 0;
    while (s !== v && k < 60)
    begin
      @(posedge clk);
      k++;
    end
    `chk(n, v, s)
  endtask : await

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run
  initial
  begin
    #100us;
    fails++;
    conclude();
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  // main sequence
  initial
  begin
    reset = 1'b1;
    {waiting_wake_tone, wake_tone_detected, activation_start, full_duplex_reached, framing_ok} = '0;
    {superframe_found, activation_timer_expired, dchannel_data_ready, maint_irq_event, rx_data_in} = '0;
    dchannel_rx_byte = 8'h00;
    high_line_error = 1'b0;
    b = 1'($urandom(32'h200e_62fd));
    step(20);
    reset <= 1'b0;
    step(1);
    rchk(8'h00, 4'hf, 4'h0);
    wr(8'h0c, 4'h2);
    dchannel_rx_byte <= 8'($urandom);
    dchannel_data_ready <= 1'b1;
    step(1);
    dchannel_data_ready <= 1'b0;
    rchk(8'h04, 4'hf, 4'hf);
    `chk("status irq", 1'b1, activation_change_interrupt)
    rchk(8'h10, 32'h0000_00ff, 32'(dchannel_rx_byte));
    rchk(8'h04, 4'hf, 4'h0);
    `chk("status irq", 1'b0, activation_change_interrupt)
    $display("test dchannel done");
    wr(8'h00, 4'hc);
    await(soft_reset_active, 1'b1, "soft reset");
    rchk(8'h00, 4'hf, 4'hc);
    rchk(8'h0c, 4'hf, 4'h2);
    wr(8'h00, 4'h0);
    await(soft_reset_active, 1'b0, "soft reset");
    $display("test soft reset done");
    waiting_wake_tone <= 1'b1;
    step(10);
    `chk("power down", 1'b0, power_down)
    wr(8'h00, 4'h4);
    await(power_down, 1'b1, "power down");
    wr(8'h00, 4'h0);
    await(power_down, 1'b0, "power down");
    wr(8'h00, 4'h4);
    await(power_down, 1'b1, "power down");
    waiting_wake_tone <= 1'b0;
    wake_tone_detected <= 1'b1;
    step(1);
    wake_tone_detected <= 1'b0;
    await(power_down, 1'b0, "power down");
    wr(8'h00, 4'h0);
    $display("test power down done");
    wr(8'h0c, 4'h0);
    wr(8'h00, 4'h2);
    await(clear_coefficients, 1'b1, "coefficients");
    await(drivers_off, 1'b1, "drivers off");
    `chk("absolute power down", 1'b1, absolute_power_down)
    wr(8'h0c, 4'h2);
    rchk(8'h00, 4'hf, 4'h0);
    wr(8'h00, 4'h0);
    wr(8'h00, 4'h8);
    step(20);
    wr(8'h00, 4'h0);
    rchk(8'h0c, 4'hf, 4'h0);
    $display("test absolute power down done");
    framing_ok <= 1'b1;
    superframe_found <= 1'b1;
    activation_start <= 1'b1;
    step(1);
    activation_start <= 1'b0;
    await(activation_change_interrupt, 1'b1, "status irq");
    rchk(8'h04, 4'hf, 4'h1);
    await(activation_change_interrupt, 1'b0, "status irq");
    full_duplex_reached <= 1'b1;
    step(1);
    full_duplex_reached <= 1'b0;
    await(activation_change_interrupt, 1'b1, "status irq");
    rchk(8'h04, 4'hf, 4'hb);
    wr(8'h08, 4'h1);
    await(rx_data_pass, 1'b1, "rx pass");
    maint_irq_event <= 1'b1;
    await(maint_irq_out, 1'b1, "maint irq");
    repeat (8)
    begin
      b = 1'($urandom);
      rx_data_in <= b;
      step(2);
      `chk("rx data", b, rx_data_out)
    end
    high_line_error <= 1'b1;
    await(rx_data_pass, 1'b0, "rx pass");
    rchk(8'h04, 4'hf, 4'ha);
    high_line_error <= 1'b0;
    await(rx_data_pass, 1'b1, "rx pass");
    // frame and superframe lost together so frame loss times out first
    superframe_found <= 1'b0;
    framing_ok <= 1'b0;
    rx_data_in <= 1'b0;
    await(rx_data_pass, 1'b0, "rx pass");
    await(maint_irq_out, 1'b0, "maint irq");
    `chk("rx data", 1'b1, rx_data_out)
    step(40);
    rchk(8'h04, 4'hc, 4'h4);
    rchk(8'h04, 4'h4, 4'h4);
    wr(8'h08, 4'h8);
    rchk(8'h04, 4'h4, 4'h0);
    activation_timer_expired <= 1'b1;
    step(1);
    activation_timer_expired <= 1'b0;
    rchk(8'h04, 4'h4, 4'h4);
    wake_tone_detected <= 1'b1;
    step(1);
    wake_tone_detected <= 1'b0;
    rchk(8'h04, 4'h4, 4'h0);
    $display("test status done");
    wr(8'h14, 9'h1ff);
    rchk(8'h14, 9'h1ff, 9'h1ff);
    wr(8'h00, 4'h1);
    rchk(8'h14, 9'h1ff, 9'h000);
    rchk(8'h1c, 4'h0, 4'h0);
    wr(8'h00, 4'h4);
    reset <= 1'b1;
    step(6);
    reset <= 1'b0;
    step(1);
    rchk(8'h00, 4'hf, 4'h0);
    $display("test maintenance and reset done");
    conclude();
  end
endmodule : testbench
